//--- hw/seq_core.sv
// Channel mode sequencer: register file, mode control and conversion starts.
//
// Summary of operation
// - Mode 00b: select-rise starts, manual channel register.
// - Mode 10b: first five input bits pick channel.
// - Mode 01b: select-rise starts, sequencer steps after each.
// - Autonomous: internal timer starts, sequencer picks channels.
// - Power-up runs manual mode until reconfigured.
// - Reset or power-up sets brownout flag.
// - Soft reset bit performs full reset.
// - Manual change decoded at select-rise; samples old channel.
// - Manual new-channel result appears two frames later.
// - On-the-fly samples new channel same frame.
// - Codes 10000-10111 pick inputs 0-7; rest reserved.
// - Sequencer steps ascending through enabled channels only.
// - Scan run 1 starts, 0 stops sequencer.
// - After highest enabled, wrap to lowest, repeat.
// - Write decoded at select-rise, data byte stored.
// - Sequencer active flag reads 1 while running.
// - Writing 1 clears brownout until next reset.
`timescale 1ns/10ps
`include "seq_params.svh"
module seq_core
   import seq_pkg::*;
#(
   parameter int AUTO_CYCLES = `AUTO_PERIOD_NS / `CORE_PERIOD_NS
)
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe,
   input  wire logic [7:0]  pin_levels,
   input  wire logic [15:0] conv_result,
   input  wire logic        conv_done,
   output conv_req_t        conv_req,
   output logic [2:0]       mux_channel
);

   localparam int NSLOTS = 16;  // Plain read/write registers held in the array.

   // Link-domain outputs.
   link_frame_t rx_frame;    // Last received frame, stable while select is high.
   logic        frame_full;  // Frame had all 24 bits.
   logic [4:0]  otf_code;    // First five bits of the running frame.
   logic        otf_valid;   // Five bits have arrived in the running frame.
   logic [23:0] tx_word;     // Word shifted out in the next frame.

   // Synchronisers; the first stage of each feeds only its second stage.
   logic       cs_meta;
   logic       cs_sync;
   logic       cs_prev;
   logic       otf_meta;
   logic       otf_sync;
   logic       otf_prev;
   logic [7:0] pins_meta;
   logic [7:0] pins_sync;

   logic       cs_rise;      // One core cycle after a settled select rising edge.
   logic       otf_rise;     // Five channel bits are ready.
   logic       soft_rst;     // Pulse from a write of the soft reset bit.
   logic       all_rst;      // Pin reset or soft reset.

   // Register storage.
   logic [7:0] regs [NSLOTS];  // Plain registers addressed by slot index.
   logic       brownout_flag;  // Set by every reset, cleared by writing 1.
   logic [7:0] rd_byte;        // Register data for the frame after a read.
   logic       read_pending;   // The next frame returns rd_byte.
   logic [23:0] result_word;   // Last result with its channel.

   // Decoded command of the frame that just ended.
   logic       cmd_valid;
   logic       cmd_modify;
   logic [3:0] cmd_slot;
   logic       cmd_hit;
   logic [7:0] cmd_new;

   // Mode and sequencer.
   scan_mode_t scan_mode_select;
   logic       scan_run;
   logic       autonomous;
   logic       sequencer_active_flag;
   logic [7:0] scan_channel_mask;
   logic [2:0] direct_channel_id;
   logic [2:0] step_next;
   logic       step_any;
   logic       conv_go;
   logic [15:0] auto_timer;  // Cycles since the last internal conversion.

   // Maps an address onto a storage slot; hit is low for unmapped and special addresses.
   function automatic logic [4:0] slot_of(input logic [7:0] a);
      case (a)
         `ADDR_CORE_SETUP:    slot_of = {1'b1, 4'h1};
         `ADDR_OUT_FORMAT:    slot_of = {1'b1, 4'h2};
         `ADDR_AVERAGING:     slot_of = {1'b1, 4'h3};
         `ADDR_OPERATION:     slot_of = {1'b1, 4'h4};
         `ADDR_PIN_FUNCTION:  slot_of = {1'b1, 4'h5};
         `ADDR_PIN_DIRECTION: slot_of = {1'b1, 4'h6};
         `ADDR_DRIVE_TYPE:    slot_of = {1'b1, 4'h7};
         `ADDR_OUT_LEVELS:    slot_of = {1'b1, 4'h8};
         `ADDR_SCAN_CONTROL:  slot_of = {1'b1, 4'h9};
         `ADDR_MANUAL_PICK:   slot_of = {1'b1, 4'hA};
         `ADDR_SCAN_ENABLES:  slot_of = {1'b1, 4'hB};
         `ADDR_UNLOCK_KEY:    slot_of = {1'b1, 4'hC};
         `ADDR_TEST_ON:       slot_of = {1'b1, 4'hD};
         `ADDR_CAPTURE_LOW:   slot_of = {1'b1, 4'hE};
         `ADDR_CAPTURE_HIGH:  slot_of = {1'b1, 4'hF};
         default:             slot_of = {1'b0, 4'h0};
      endcase
   endfunction

   // Applies a write, set-bits or clear-bits command to an old register value.
   function automatic logic [7:0] modify(input logic [7:0] old, input logic [7:0] op,
                                         input logic [7:0] d);
      case (op)
         `OP_WRITE:      modify = d;
         `OP_SET_BITS:   modify = old | d;
         `OP_CLEAR_BITS: modify = old & ~d;
         default:        modify = old;
      endcase
   endfunction

   // Reset value of each slot.
   function automatic logic [7:0] slot_reset(input int s);
      slot_reset = (s == 4) ? `RST_OPERATION : `RST_ZERO;
   endfunction

   // Serial link in the host clock domain.
   link_shifter u_link (
      .sclk       (sclk),
      .cs_n       (cs_n),
      .sdi        (sdi),
      .tx_word    (tx_word),
      .rx_frame   (rx_frame),
      .frame_full (frame_full),
      .otf_code   (otf_code),
      .otf_valid  (otf_valid),
      .sdo        (sdo),
      .sdo_oe     (sdo_oe)
   );

   // Next enabled channel after the current multiplexer setting.
   scan_stepper u_step (
      .mask         (scan_channel_mask),
      .current      (mux_channel),
      .next_channel (step_next),
      .any_enabled  (step_any)
   );

   // Two-stage synchronisers for select, the channel-code level and the pins.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cs_meta   <= 1'b1;
         cs_sync   <= 1'b1;
         cs_prev   <= 1'b1;
         otf_meta  <= 1'b0;
         otf_sync  <= 1'b0;
         otf_prev  <= 1'b0;
         pins_meta <= 8'h00;
         pins_sync <= 8'h00;
      end else begin
         cs_meta   <= cs_n;
         cs_sync   <= cs_meta;
         cs_prev   <= cs_sync;
         otf_meta  <= otf_valid;
         otf_sync  <= otf_meta;
         otf_prev  <= otf_sync;
         pins_meta <= pin_levels;
         pins_sync <= pins_meta;
      end
   end

   // Frame data is quiet once select is high, so it is read after the synchronised edge.
   always_comb begin
      cs_rise    = cs_sync & ~cs_prev;
      otf_rise   = otf_sync & ~otf_prev;
      all_rst    = rst | soft_rst;
      cmd_valid  = cs_rise & frame_full;
      cmd_modify = cmd_valid & ((rx_frame.opcode == `OP_WRITE) |
                                (rx_frame.opcode == `OP_SET_BITS) |
                                (rx_frame.opcode == `OP_CLEAR_BITS));
      {cmd_hit, cmd_slot} = slot_of(rx_frame.addr);
      cmd_new    = modify(regs[cmd_slot], rx_frame.opcode, rx_frame.data);
   end

   // Soft reset is a one-cycle pulse after the write; it clears itself with the register.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= cmd_modify & (rx_frame.addr == `ADDR_CORE_SETUP) &
                     cmd_new[`BIT_SOFT_RESET];
      end
   end

   // Register writes are taken only from complete frames at the select rising edge.
   always_ff @(posedge core_clk) begin
      if (all_rst) begin
         for (int s = 0; s < NSLOTS; s++) begin
            regs[s] <= slot_reset(s);
         end
      end else if (cmd_modify && cmd_hit) begin
         regs[cmd_slot] <= cmd_new;
      end
   end

   // Brownout only ever rises on reset; a reset in the same cycle as a clear wins and leaves the flag set.
   always_ff @(posedge core_clk) begin
      if (all_rst) begin
         brownout_flag <= 1'b1;
      end else if (cmd_modify && rx_frame.addr == `ADDR_STATE_FLAGS &&
                   rx_frame.opcode != `OP_CLEAR_BITS && rx_frame.data[`BIT_BROWNOUT]) begin
         brownout_flag <= 1'b0;
      end
   end

   // Register fields that steer the block.
   always_comb begin
      scan_mode_select      = scan_mode_t'(regs[9][`SCAN_MODE_LSB +: 2]);
      scan_run              = regs[9][`BIT_SCAN_RUN];
      scan_channel_mask     = regs[11];
      direct_channel_id     = regs[10][2:0];
      autonomous            = regs[4][`BIT_AUTONOMOUS];
      sequencer_active_flag = scan_run & (scan_mode_select == MODE_SCAN);
   end

   // A read command latches the addressed byte for the following frame.
   always_ff @(posedge core_clk) begin
      if (all_rst) begin
         read_pending <= 1'b0;
         rd_byte      <= 8'h00;
      end else if (cs_rise) begin
         read_pending <= cmd_valid & (rx_frame.opcode == `OP_READ);
         if (rx_frame.addr == `ADDR_STATE_FLAGS) begin
            rd_byte <= {1'b1, sequencer_active_flag, 5'h00, brownout_flag};
         end else if (rx_frame.addr == `ADDR_IN_LEVELS) begin
            rd_byte <= pins_sync;
         end else if (cmd_hit) begin
            rd_byte <= regs[cmd_slot];
         end else begin
            rd_byte <= 8'h00;
         end
      end
   end

   // Internal conversion timer, running only for the autonomous scan.
   always_ff @(posedge core_clk) begin
      if (all_rst || !(autonomous && sequencer_active_flag)) begin
         auto_timer <= 16'h0000;
      end else if (auto_timer == 16'(AUTO_CYCLES - 1)) begin
         auto_timer <= 16'h0000;
      end else begin
         auto_timer <= auto_timer + 16'h0001;
      end
   end

   // Conversions follow select in every mode except the autonomous one.
   always_comb begin
      if (autonomous && sequencer_active_flag) begin
         conv_go = (auto_timer == 16'(AUTO_CYCLES - 1));
      end else begin
         conv_go = cs_rise;
      end
   end

   // The conversion takes the multiplexer as it stands before this cycle's update.
   always_ff @(posedge core_clk) begin
      if (all_rst) begin
         conv_req <= '0;
      end else begin
         conv_req.start <= conv_go;
         if (conv_go) begin
            conv_req.channel <= mux_channel;
         end
      end
   end

   // Multiplexer control per mode.
   always_ff @(posedge core_clk) begin
      if (all_rst) begin
         mux_channel <= 3'h0;
      end else begin
         case (scan_mode_select)
            MODE_MANUAL: begin
               // Follows the register, which changes in the cycle the old channel is sampled.
               mux_channel <= direct_channel_id;
            end
            MODE_OTF: begin
               // Only 1 0xxx codes select an input; 1 1xxx and 0xxxx leave it alone.
               if (otf_rise && otf_code[4] && !otf_code[3]) begin
                  mux_channel <= otf_code[2:0];
               end
            end
            MODE_SCAN: begin
               if (conv_go && scan_run && step_any) begin
                  mux_channel <= step_next;
               end
            end
            default: begin
               mux_channel <= mux_channel;
            end
         endcase
      end
   end

   // Results carry their channel in the third byte.
   always_ff @(posedge core_clk) begin
      if (all_rst) begin
         result_word <= 24'h000000;
      end else if (conv_done) begin
         result_word <= {conv_result, 1'b0, conv_req.channel, 4'h0};
      end
   end

   // The outgoing word changes only while the link is idle, so a frame never sees it move.
   always_ff @(posedge core_clk) begin
      if (all_rst) begin
         tx_word <= 24'h000000;
      end else if (cs_sync) begin
         tx_word <= read_pending ? {rd_byte, 16'h0000} : result_word;
      end
   end

endmodule

//--- inc/seq_params.svh
// Register map, field positions, reset values, opcodes and timing counts of the sequencer.
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

// Register addresses as carried in the second byte of a frame.
`define ADDR_STATE_FLAGS   8'h00
`define ADDR_CORE_SETUP    8'h01
`define ADDR_OUT_FORMAT    8'h02
`define ADDR_AVERAGING     8'h03
`define ADDR_OPERATION     8'h04
`define ADDR_PIN_FUNCTION  8'h05
`define ADDR_PIN_DIRECTION 8'h07
`define ADDR_DRIVE_TYPE    8'h09
`define ADDR_OUT_LEVELS    8'h0B
`define ADDR_IN_LEVELS     8'h0D
`define ADDR_SCAN_CONTROL  8'h10
`define ADDR_MANUAL_PICK   8'h11
`define ADDR_SCAN_ENABLES  8'h12
`define ADDR_UNLOCK_KEY    8'hBF
`define ADDR_TEST_ON       8'hC0
`define ADDR_CAPTURE_LOW   8'hC1
`define ADDR_CAPTURE_HIGH  8'hC2

// Reset values; every register not listed here resets to zero.
`define RST_STATE_FLAGS    8'h81
`define RST_OPERATION      8'h04
`define RST_ZERO           8'h00

// Field positions.
`define BIT_BROWNOUT       0
`define BIT_SEQ_ACTIVE     6
`define BIT_FLAGS_ONE      7
`define BIT_SOFT_RESET     0
`define BIT_AUTONOMOUS     5
`define BIT_SCAN_RUN       4
`define SCAN_MODE_LSB      0

// Command opcodes in the first byte of a frame.
`define OP_READ            8'h10
`define OP_WRITE           8'h08
`define OP_SET_BITS        8'h18
`define OP_CLEAR_BITS      8'h20

// Frame and channel-code geometry.
`define FRAME_BITS         24
`define OTF_BITS           5

// Timing: core clock period and interval of internally timed conversions.
`define CORE_PERIOD_NS     20
`define AUTO_PERIOD_NS     4000

`endif

//--- inc/seq_pkg.sv
// Types shared by the sequencer core, its serial link and its channel stepper.
package seq_pkg;

   // Scan mode select codes.
   typedef enum logic [1:0] {
      MODE_MANUAL = 2'h0,
      MODE_SCAN   = 2'h1,
      MODE_OTF    = 2'h2,
      MODE_RSVD   = 2'h3
   } scan_mode_t;

   // One received 24-bit command frame, first bit in the opcode MSB.
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] addr;
      logic [7:0] data;
   } link_frame_t;

   // Conversion request towards the analog core.
   typedef struct packed {
      logic       start;
      logic [2:0] channel;
   } conv_req_t;

endpackage

//--- hw/scan_stepper.sv
// Picks the next enabled channel above the current one, wrapping to the lowest.
`timescale 1ns/10ps
module scan_stepper
   import seq_pkg::*;
(
   input  wire logic [7:0] mask,
   input  wire logic [2:0] current,
   output logic      [2:0] next_channel,
   output logic            any_enabled
);

   // Searches upward from current+1 with wrap; returns current when nothing is enabled.
   function automatic logic [2:0] next_enabled(input logic [7:0] m, input logic [2:0] cur);
      logic [2:0] pick;
      logic [2:0] cand;
      logic       found;
      pick  = cur;
      found = 1'b0;
      for (int i = 1; i <= 8; i++) begin
         cand = cur + i[2:0];
         if (!found && m[cand]) begin
            pick  = cand;
            found = 1'b1;
         end
      end
      return pick;
   endfunction

   // Ascending order with wrap from the highest to the lowest enabled input.
   always_comb begin
      next_channel = next_enabled(mask, current);
      any_enabled  = |mask;
   end

endmodule

//--- hw/link_shifter.sv
// Serial link front end clocked by the host's serial clock (mode 0 only).
`timescale 1ns/10ps
module link_shifter
   import seq_pkg::*;
(
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        sdi,
   input  wire logic [23:0] tx_word,
   output link_frame_t      rx_frame,
   output logic             frame_full,
   output logic [4:0]       otf_code,
   output logic             otf_valid,
   output logic             sdo,
   output logic             sdo_oe
);

   logic [4:0]  bit_count;  // Bits taken in this frame; cleared while the frame is idle.
   logic [23:0] shift_in;   // Incoming bits, first bit ends up in the MSB.
   logic        sdo_q;      // Output bit launched on the falling edge.

   // The serial clock stops between frames, so chip select clears the count directly.
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_count <= 5'h00;
      end else if (bit_count != 5'(`FRAME_BITS)) begin
         bit_count <= bit_count + 5'h01;
      end
   end

   // Bits beyond the 24th are ignored so the frame stays intact.
   always_ff @(posedge sclk) begin
      if (bit_count != 5'(`FRAME_BITS)) begin
         shift_in <= {shift_in[22:0], sdi};
      end
   end

   // Marks a complete frame; a short frame of the next transfer clears it at its first bit.
   always_ff @(posedge sclk) begin
      frame_full <= (bit_count == 5'(`FRAME_BITS - 1)) || (bit_count == 5'(`FRAME_BITS));
   end

   // The first five bits are kept once, before the frame ends.
   always_ff @(posedge sclk) begin
      if (bit_count == 5'(`OTF_BITS - 1)) begin
         otf_code <= {shift_in[3:0], sdi};
      end
   end

   // Level seen by the core domain; cleared by chip select, not by a clock edge.
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         otf_valid <= 1'b0;
      end else if (bit_count == 5'(`OTF_BITS - 1)) begin
         otf_valid <= 1'b1;
      end
   end

   // Next output bit after each capture edge.
   always_ff @(negedge sclk) begin
      if (bit_count < 5'(`FRAME_BITS)) begin
         sdo_q <= tx_word[5'(`FRAME_BITS - 1) - bit_count];
      end else begin
         sdo_q <= 1'b0;
      end
   end

   // The first bit must stand at the select falling edge, before any clock edge.
   always_comb begin
      rx_frame = link_frame_t'(shift_in);
      sdo      = (bit_count == 5'h00) ? tx_word[23] : sdo_q;
      sdo_oe   = ~cs_n;
   end

endmodule

//--- test/host_link.sv
// Serial host model that drives whole mode-0 frames and captures the reply word.
`timescale 1ns/10ps
module host_link (
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo
);
   // The select idles high and the serial clock stands still outside frames.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   // One frame of 24 clocks, MSB first; the odd lead-in and tail drift the phase.
   task automatic frame(input logic [23:0] word, output logic [23:0] rx);
      #13 cs_n = 1'b0;
      #160;
      for (int i = 23; i >= 0; i--) begin
         sdi = word[i];
         #80 sclk = 1'b1;
         rx[i] = sdo;
         #80 sclk = 1'b0;
      end
      #80 cs_n = 1'b1;
      // A released line shows the inverse, so nothing leans on a held value.
      sdi = ~sdi;
      #413;
   endtask
endmodule

//--- test/seq_core_asserts.sv
// Concurrent checks on the ports of the sequencer core.
`timescale 1ns/10ps
module seq_core_asserts
   import seq_pkg::*;
#(
   parameter int AUTO_CYCLES = 200
)
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        sclk,
   input wire logic        cs_n,
   input wire logic        sdi,
   input wire logic        sdo,
   input wire logic        sdo_oe,
   input wire logic [7:0]  pin_levels,
   input wire logic [15:0] conv_result,
   input wire logic        conv_done,
   input wire conv_req_t   conv_req,
   input wire logic [2:0]  mux_channel
);
   logic [3:0] since_evt; // Cycles since the select was low or a conversion began.

   // The multiplexer may only move during or shortly after a frame, or shortly after a conversion start.
   always_ff @(posedge core_clk) begin
      if (rst || !cs_n || conv_req.start)
         since_evt <= 4'h0;
      else if (since_evt != 4'hF)
         since_evt <= since_evt + 4'h1;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_reset_clears: assert property ($fell(rst) |-> conv_req == '0 && mux_channel == 3'h0)
      else $error("outputs not cleared by reset");
   a_start_single: assert property (conv_req.start |=> !conv_req.start)
      else $error("start longer than one cycle");
   a_start_after_rise: assert property ($rose(cs_n) |-> ##[1:8] conv_req.start)
      else $error("no start after select rise");
   a_start_when_idle: assert property (conv_req.start |-> cs_n && $past(cs_n))
      else $error("start inside a frame");
   // A soft reset clears the channel one cycle after the conversion start of the frame that asked for it.
   a_chan_holds: assert property (!conv_req.start |-> $stable(conv_req.channel) ||
         ($past(conv_req.start) && conv_req.channel == 3'h0))
      else $error("channel moved without a start");
   a_chan_from_mux: assert property (conv_req.start |->
         conv_req.channel == $past(mux_channel))
      else $error("start channel differs from multiplexer");
   a_mux_on_event: assert property ($changed(mux_channel) |-> since_evt <= 4'h8)
      else $error("multiplexer moved with no cause");
   a_oe_select: assert property (sdo_oe == !cs_n)
      else $error("output enable differs from select");

   c_otf_move: cover property (!cs_n && $changed(mux_channel));
   c_auto_pair: cover property (conv_req.start ##8 conv_req.start);
   c_frame_start: cover property ($rose(cs_n) ##[1:8] conv_req.start);
endmodule

bind seq_core seq_core_asserts #(.AUTO_CYCLES(AUTO_CYCLES)) chk_u (
   .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
   .sdo_oe(sdo_oe), .pin_levels(pin_levels), .conv_result(conv_result),
   .conv_done(conv_done), .conv_req(conv_req), .mux_channel(mux_channel));

//--- test/testbench.sv
// Self-checking bench: host frames against the sequencer core with a simple analog model.
`timescale 1ns/10ps
`include "seq_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module testbench
   import seq_pkg::*;
   ;
   logic        core_clk    = 1'b0;
   logic        rst         = 1'b1;
   logic        sclk, cs_n, sdi, sdo, sdo_oe;
   logic [7:0]  pin_levels  = 8'h5A;
   logic [15:0] conv_result = 16'h0000;
   logic        conv_done   = 1'b0;
   conv_req_t   conv_req;
   logic [2:0]  mux_channel;
   logic [23:0] rx;            // Last reply word.
   logic [2:0]  m;             // Multiplexer before a frame.
   int          n_fail = 0, n_tests = 0, n_starts = 0, n0;
   logic [7:0]  rw_addr [10] = '{`ADDR_OUT_FORMAT, `ADDR_AVERAGING, `ADDR_PIN_FUNCTION,
      `ADDR_PIN_DIRECTION, `ADDR_DRIVE_TYPE, `ADDR_OUT_LEVELS, `ADDR_UNLOCK_KEY,
      `ADDR_TEST_ON, `ADDR_CAPTURE_LOW, `ADDR_CAPTURE_HIGH};

   always #10 core_clk = ~core_clk;

   // Analog core: answers each start one cycle later with a tagged result.
   always @(posedge core_clk) begin
      conv_done   <= conv_req.start;
      conv_result <= {8'hA5, 5'h00, conv_req.channel};
      if (conv_req.start)
         n_starts <= n_starts + 1;
   end

   seq_core #(.AUTO_CYCLES(8)) dut_u (.core_clk(core_clk), .rst(rst), .sclk(sclk),
      .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .pin_levels(pin_levels),
      .conv_result(conv_result), .conv_done(conv_done), .conv_req(conv_req),
      .mux_channel(mux_channel));
   host_link host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   // A read takes two frames; the register comes back in the first byte.
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host_u.frame({`OP_READ, a, 8'h00}, rx);
      host_u.frame(24'h000000, rx);
      `CHK($sformatf("reg %0h", a), e, rx[23:16])
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.frame({`OP_WRITE, a, d}, rx);
   endtask

   task automatic wrap_up;
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // A hang is cut short well beyond the expected run of about 27000 cycles.
   initial begin
      repeat (60000) @(posedge core_clk);
      n_fail++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      rchk(`ADDR_STATE_FLAGS, `RST_STATE_FLAGS);
      rchk(`ADDR_OPERATION, `RST_OPERATION);
      rchk(`ADDR_SCAN_CONTROL, `RST_ZERO);
      rchk(8'h06, 8'h00);
      wr(`ADDR_IN_LEVELS, 8'hFF);
      rchk(`ADDR_IN_LEVELS, 8'h5A);
      foreach (rw_addr[i]) begin
         rchk(rw_addr[i], `RST_ZERO);
         wr(rw_addr[i], 8'hC3 ^ rw_addr[i]);
         rchk(rw_addr[i], 8'hC3 ^ rw_addr[i]);
      end
      host_u.frame({`OP_SET_BITS, `ADDR_OUT_FORMAT, 8'h0C}, rx);
      host_u.frame({`OP_CLEAR_BITS, `ADDR_OUT_FORMAT, 8'h81}, rx);
      rchk(`ADDR_OUT_FORMAT, 8'h4C);
      // Manual pick: old channel now, new one next, its result two frames on.
      wr(`ADDR_MANUAL_PICK, 8'h03);
      `CHK("start channel", 3'h0, conv_req.channel)
      `CHK("manual mux", 3'h3, mux_channel)
      host_u.frame(24'h000000, rx);
      `CHK("next channel", 3'h3, conv_req.channel)
      host_u.frame(24'h000000, rx);
      `CHK("result word", 24'hA50330, rx)
      wr(`ADDR_STATE_FLAGS, 8'h01);
      rchk(`ADDR_STATE_FLAGS, 8'h80);
      wr(`ADDR_CORE_SETUP, 8'h01);
      rchk(`ADDR_STATE_FLAGS, 8'h81);
      rchk(`ADDR_MANUAL_PICK, 8'h00);
      rchk(`ADDR_CORE_SETUP, 8'h00);
      `CHK("mux after soft reset", 3'h0, mux_channel)
      // On-the-fly codes, the reserved 1 1xxx ones leave the last pick in place.
      wr(`ADDR_SCAN_CONTROL, 8'h02);
      for (int c = 0; c < 16; c++) begin
         host_u.frame({1'b1, 4'(c), 19'h00000}, rx);
         `CHK("otf mux", (c < 8) ? 3'(c) : 3'h7, mux_channel)
         `CHK("otf start", (c < 8) ? 3'(c) : 3'h7, conv_req.channel)
      end
      // The reserved mode code freezes the multiplexer, even against a valid channel code.
      wr(`ADDR_SCAN_CONTROL, 8'h03);
      host_u.frame(24'h900000, rx);
      `CHK("reserved mode mux", 3'h7, mux_channel)
      `CHK("reserved mode start", 3'h7, conv_req.channel)
      wr(`ADDR_SCAN_CONTROL, 8'h00);
      // Scan over inputs 2 and 6 with wrap-around.
      wr(`ADDR_SCAN_ENABLES, 8'h44);
      wr(`ADDR_SCAN_CONTROL, 8'h11);
      rchk(`ADDR_STATE_FLAGS, 8'hC1);
      repeat (4) begin
         m = mux_channel;
         host_u.frame(24'h000000, rx);
         `CHK("scan start", m, conv_req.channel)
         `CHK("scan step", (m == 3'h2) ? 3'h6 : 3'h2, mux_channel)
      end
      wr(`ADDR_SCAN_CONTROL, 8'h01);
      m = mux_channel;
      rchk(`ADDR_STATE_FLAGS, 8'h81);
      `CHK("scan stopped", m, mux_channel)
      wr(`ADDR_SCAN_ENABLES, 8'h00);
      wr(`ADDR_SCAN_CONTROL, 8'h11);
      m = mux_channel;
      host_u.frame(24'h000000, rx);
      `CHK("empty mask", m, mux_channel)
      // Autonomous timing: starts come from the timer with the select idle.
      wr(`ADDR_SCAN_ENABLES, 8'h81);
      wr(`ADDR_OPERATION, 8'h24);
      n0 = n_starts;
      repeat (80) @(posedge core_clk);
      #1;
      `CHK("auto starts", 10, n_starts - n0)
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK("mux after reset", 3'h0, mux_channel)
      rchk(`ADDR_STATE_FLAGS, `RST_STATE_FLAGS);
      rchk(`ADDR_OPERATION, `RST_OPERATION);
      wrap_up();
   end
endmodule
